// ### pkg/nvpp_defs.svh
// constants of the parallel programming port: pin codes, commands, fields, times
// assumes inclusion by bare name; definitions only
`ifndef NVPP_DEFS_SVH
`define NVPP_DEFS_SVH

// action codes on the two xtal action pins
`define NVPP_XA_ADDR 2'h0
`define NVPP_XA_DATA 2'h1
`define NVPP_XA_CMD 2'h2
`define NVPP_XA_IDLE 2'h3

// command bytes
`define NVPP_CMD_ERASE 8'h80
`define NVPP_CMD_FUSE_WR 8'h40
`define NVPP_CMD_LOCK_WR 8'h20
`define NVPP_CMD_FLASH_WR 8'h10
`define NVPP_CMD_EE_WR 8'h11
`define NVPP_CMD_SIG_RD 8'h08
`define NVPP_CMD_FL_RD 8'h04
`define NVPP_CMD_FLASH_RD 8'h02
`define NVPP_CMD_EE_RD 8'h03

// fuse byte fields, lock byte fields
`define NVPP_FUSE_SERIAL_BIT 5
`define NVPP_FUSE_EE_KEEP_BIT 3
`define NVPP_FUSE_SUT_HI_BIT 1
`define NVPP_FUSE_SUT_LO_BIT 0
`define NVPP_FUSE_RSV_MASK 8'hd4
`define NVPP_LOCK_HI_BIT 2
`define NVPP_LOCK_LO_BIT 1

// reset and erased values
`define NVPP_FUSE_RST 8'hff
`define NVPP_LOCK_RST 2'h3
`define NVPP_ERASED 8'hff
`define NVPP_SIG_COUNT 8'h03

// times in ns and the clock period
`define NVPP_CLK_PERIOD_NS 100
`define NVPP_BUSY_TIME_NS 700000
`define NVPP_FUSE_PULSE_MIN_NS 1000000
`define NVPP_ERASE_PULSE_MIN_NS 5000000
`define NVPP_BUSY_CYC (`NVPP_BUSY_TIME_NS / `NVPP_CLK_PERIOD_NS)
`define NVPP_FUSE_MIN_CYC ((`NVPP_FUSE_PULSE_MIN_NS + `NVPP_CLK_PERIOD_NS - 1) / `NVPP_CLK_PERIOD_NS)
`define NVPP_ERASE_MIN_CYC ((`NVPP_ERASE_PULSE_MIN_NS + `NVPP_CLK_PERIOD_NS - 1) / `NVPP_CLK_PERIOD_NS)

`endif

// ### pkg/nvpp_pkg.sv
// types of the parallel programming port
// assumes nothing beyond a SystemVerilog compiler
package nvpp_pkg;

	// sampled programming pins
	typedef struct packed {
		logic [1:0] xa;
		logic bs;
		logic lsc;
		logic wr_n;
		logic oe_n;
		logic page_latch_strobe;
		logic [7:0] data;
	} nvpp_pins_t;

	// sequencer states
	typedef enum logic [1:0] {
		NVPP_IDLE,
		NVPP_BUSY,
		NVPP_ERASE
	} nvpp_state_t;

endpackage : nvpp_pkg

// ### design/nvpp_mem.sv
// single-port memory with registered read data
// assumes one clock, write and read at the same address
`timescale 1ns/1ps

module nvpp_mem #(
	parameter int W = 8,
	parameter int AW = 12
) (
	// clock
	input wire logic clk_i,
	// access
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [W-1:0] wdata_i,
	output logic [W-1:0] rdata_o
);
	logic [W-1:0] mem [0:(1<<AW)-1];

	// write port
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
	end

	// registered read
	always_ff @(posedge clk_i) begin
		rdata_o <= mem[addr_i];
	end
endmodule : nvpp_mem

// ### design/nvpp_top.sv
// parallel programming port: byte loader, flash and eeprom arrays, fuses and locks
// assumes programming pins synchronous to CLOCK_I and the device already in programming mode
// Function
// - whole flash is written by repeating the page sequence per page
// - eeprom write loads command 11h, address high, low, then data low
// - write strobe falling with byte select low starts eeprom write, busy low
// - command and address stay unchanged while programming runs
// - loaded command stays in force across many accesses
// - address high byte kept until reloaded
// - flash read uses command 02h and both address bytes
// - flash read gives low byte with byte select 0, high with 1
// - eeprom read uses command 03h, drives addressed byte
// - fuse write command 40h, data bits 5, 3, 1, 0 are fuses
// - fuse bit 0 programs, 1 erases; reserved bits stay 1
// - fuse write executes on a strobe of at least 1.0 ms, no busy
// - lock write command 20h, bits 2 and 1, 0 programs
// - locks return unprogrammed only through chip erase
// - command 04h with byte select low reads fuse states
// - same mode with byte select high reads lock states
// - signature read command 08h, address low 0 to 2
// - busy stays low 0.5 to 0.9 ms after a write strobe
// - load strobe rise: 00 address, 01 data, 10 command, 11 nothing
// - ready low while busy, high when ready
`timescale 1ns/1ps
`include "nvpp_defs.svh"

module nvpp_top import nvpp_pkg::*; #(
	parameter int FLASH_AW = 16,
	parameter int EE_AW = 12,
	parameter int BUSY_CYC = `NVPP_BUSY_CYC,
	parameter int FUSE_MIN_CYC = `NVPP_FUSE_MIN_CYC,
	parameter int ERASE_MIN_CYC = `NVPP_ERASE_MIN_CYC,
	// signature bytes, values arbitrary
	parameter logic [7:0] SIG0 = 8'h5a,
	parameter logic [7:0] SIG1 = 8'ha5,
	parameter logic [7:0] SIG2 = 8'h3c
) (
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	// programming strobes and selects
	input wire logic XTAL_ACTION_HI_I,
	input wire logic XTAL_ACTION_LO_I,
	input wire logic BYTE_SELECT_I,
	input wire logic LOAD_STROBE_CLOCK_I,
	input wire logic WRITE_STROBE_N_I,
	input wire logic OUTPUT_ENABLE_N_I,
	input wire logic PAGE_LATCH_STROBE_I,
	// bidirectional data bus
	input wire logic [7:0] DATA_I,
	output logic [7:0] DATA_O,
	output logic DATA_OE_O,
	// status
	output logic READY_BUSY_N_O,
	output logic [7:0] FUSE_STATE_O,
	output logic [1:0] LOCK_STATE_O
);
	localparam int CW = 20;
	localparam logic [CW-1:0] BUSY_N = CW'(BUSY_CYC);
	localparam logic [CW-1:0] FUSE_N = CW'(FUSE_MIN_CYC);
	localparam logic [CW-1:0] ERASE_N = CW'(ERASE_MIN_CYC);

	nvpp_pins_t p, pq;
	nvpp_state_t state_q;
	logic [7:0] cmd_q, addr_hi_q, addr_lo_q, data_lo_q, data_hi_q;
	logic [15:0] word_q;
	logic [7:0] fuse_q;
	logic [1:0] lock_q;
	logic [CW-1:0] busy_cnt_q, wr_cnt_q;
	logic [FLASH_AW-1:0] sweep_q;
	logic lsc_rise, wr_fall, wr_rise, page_latch_strobe_rise, idle, prog_ok, wr_start;
	logic [FLASH_AW-1:0] f_addr;
	logic [EE_AW-1:0] e_addr;
	logic f_we, e_we;
	logic [15:0] f_wd, f_rd;
	logic [7:0] e_wd, e_rd;
	logic [7:0] rd_byte;

	// true for command bytes that put data on the bus
	function automatic logic is_read(input logic [7:0] c);
		is_read = (c == `NVPP_CMD_FLASH_RD) || (c == `NVPP_CMD_EE_RD)
			|| (c == `NVPP_CMD_FL_RD) || (c == `NVPP_CMD_SIG_RD);
	endfunction : is_read

	// pin bundle and its previous sample for edge detection
	assign p = '{xa: {XTAL_ACTION_HI_I, XTAL_ACTION_LO_I}, bs: BYTE_SELECT_I,
		lsc: LOAD_STROBE_CLOCK_I, wr_n: WRITE_STROBE_N_I, oe_n: OUTPUT_ENABLE_N_I,
		page_latch_strobe: PAGE_LATCH_STROBE_I, data: DATA_I};

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			pq <= '{xa: `NVPP_XA_IDLE, bs: 1'b0, lsc: 1'b0, wr_n: 1'b1, oe_n: 1'b1,
				page_latch_strobe: 1'b0, data: 8'h00};
		end else begin
			pq <= p;
		end
	end

	// strobe edges
	assign lsc_rise = p.lsc & ~pq.lsc;
	assign wr_fall = ~p.wr_n & pq.wr_n;
	assign wr_rise = p.wr_n & ~pq.wr_n;
	assign page_latch_strobe_rise = p.page_latch_strobe & ~pq.page_latch_strobe;
	assign idle = (state_q == NVPP_IDLE);
	// lock low bit programmed forbids further array writes
	assign prog_ok = idle & lock_q[0];
	// array or lock write starting on the write strobe
	assign wr_start = wr_fall & idle & ~p.bs & (((cmd_q == `NVPP_CMD_EE_WR
		|| cmd_q == `NVPP_CMD_FLASH_WR) && prog_ok) || cmd_q == `NVPP_CMD_LOCK_WR);

	// command and address loading, frozen unless idle
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			cmd_q <= 8'h00;
			addr_hi_q <= 8'h00;
			addr_lo_q <= 8'h00;
		end else if (lsc_rise && idle) begin
			case (p.xa)
				`NVPP_XA_CMD: cmd_q <= p.data;
				`NVPP_XA_ADDR: begin
					if (p.bs) begin
						addr_hi_q <= p.data;
					end else begin
						addr_lo_q <= p.data;
					end
				end
				default: ;
			endcase
		end
	end

	// data byte loading and page word latch
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			data_lo_q <= 8'h00;
			data_hi_q <= 8'h00;
			word_q <= 16'h0000;
		end else begin
			if (lsc_rise && p.xa == `NVPP_XA_DATA) begin
				if (p.bs) begin
					data_hi_q <= p.data;
				end else begin
					data_lo_q <= p.data;
				end
			end
			if (page_latch_strobe_rise) begin
				if (p.bs) begin
					word_q[15:8] <= data_hi_q;
				end else begin
					word_q[7:0] <= data_lo_q;
				end
			end
		end
	end

	// write strobe low-time counter for fuse and erase pulses
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			wr_cnt_q <= '0;
		end else if (p.wr_n) begin
			wr_cnt_q <= '0;
		end else if (wr_cnt_q != '1) begin
			wr_cnt_q <= wr_cnt_q + CW'(1);
		end
	end

	// sequencer: busy after array writes, silent sweep for chip erase
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			state_q <= NVPP_IDLE;
			busy_cnt_q <= '0;
			sweep_q <= '0;
		end else begin
			case (state_q)
				NVPP_IDLE: begin
					if (wr_start) begin
						state_q <= NVPP_BUSY;
						busy_cnt_q <= '0;
					end else if (wr_rise && cmd_q == `NVPP_CMD_ERASE
						&& wr_cnt_q >= ERASE_N) begin
						state_q <= NVPP_ERASE;
						sweep_q <= '0;
					end
				end
				NVPP_BUSY: begin
					if (busy_cnt_q == BUSY_N - CW'(1)) begin
						state_q <= NVPP_IDLE;
					end else begin
						busy_cnt_q <= busy_cnt_q + CW'(1);
					end
				end
				NVPP_ERASE: begin
					if (sweep_q == '1) begin
						state_q <= NVPP_IDLE;
					end else begin
						sweep_q <= sweep_q + FLASH_AW'(1);
					end
				end
				default: state_q <= NVPP_IDLE;
			endcase
		end
	end

	// fuse and lock bits
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			fuse_q <= `NVPP_FUSE_RST;
			lock_q <= `NVPP_LOCK_RST;
		end else begin
			if (wr_rise && idle && cmd_q == `NVPP_CMD_FUSE_WR && wr_cnt_q >= FUSE_N) begin
				fuse_q <= data_lo_q | `NVPP_FUSE_RSV_MASK;
			end
			if (wr_start && cmd_q == `NVPP_CMD_LOCK_WR) begin
				// only programs: a one never raises a zero
				lock_q <= lock_q & {data_lo_q[`NVPP_LOCK_HI_BIT],
					data_lo_q[`NVPP_LOCK_LO_BIT]};
			end else if (state_q == NVPP_ERASE && sweep_q == '1) begin
				lock_q <= `NVPP_LOCK_RST;
			end
		end
	end

	// array addressing and write enables
	assign f_addr = (state_q == NVPP_ERASE) ? sweep_q : FLASH_AW'({addr_hi_q, addr_lo_q});
	assign e_addr = (state_q == NVPP_ERASE) ? sweep_q[EE_AW-1:0]
		: EE_AW'({addr_hi_q, addr_lo_q});
	assign f_we = (state_q == NVPP_ERASE)
		|| (wr_start && cmd_q == `NVPP_CMD_FLASH_WR);
	// eeprom keep fuse programmed spares the eeprom from erase
	assign e_we = (state_q == NVPP_ERASE && fuse_q[`NVPP_FUSE_EE_KEEP_BIT])
		|| (wr_start && cmd_q == `NVPP_CMD_EE_WR);
	assign f_wd = (state_q == NVPP_ERASE) ? {`NVPP_ERASED, `NVPP_ERASED} : word_q;
	assign e_wd = (state_q == NVPP_ERASE) ? `NVPP_ERASED : data_lo_q;

	nvpp_mem #(.W(16), .AW(FLASH_AW)) u_flash (
		.clk_i(CLOCK_I),
		.we_i(f_we),
		.addr_i(f_addr),
		.wdata_i(f_wd),
		.rdata_o(f_rd)
	);

	nvpp_mem #(.W(8), .AW(EE_AW)) u_eeprom (
		.clk_i(CLOCK_I),
		.we_i(e_we),
		.addr_i(e_addr),
		.wdata_i(e_wd),
		.rdata_o(e_rd)
	);

	// read byte selection by command and byte select
	always_comb begin
		rd_byte = 8'hff;
		case (cmd_q)
			`NVPP_CMD_FLASH_RD: rd_byte = p.bs ? f_rd[15:8] : f_rd[7:0];
			`NVPP_CMD_EE_RD: rd_byte = e_rd;
			`NVPP_CMD_FL_RD: begin
				if (p.bs) begin
					rd_byte = {5'h1f, lock_q, 1'b1};
				end else begin
					rd_byte = fuse_q;
				end
			end
			`NVPP_CMD_SIG_RD: begin
				case (addr_lo_q)
					8'h00: rd_byte = SIG0;
					8'h01: rd_byte = SIG1;
					8'h02: rd_byte = SIG2;
					default: rd_byte = 8'hff;
				endcase
			end
			default: rd_byte = 8'hff;
		endcase
	end

	// registered bus drive and status outputs
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			DATA_O <= 8'h00;
			DATA_OE_O <= 1'b0;
			READY_BUSY_N_O <= 1'b1;
			FUSE_STATE_O <= `NVPP_FUSE_RST;
			LOCK_STATE_O <= `NVPP_LOCK_RST;
		end else begin
			DATA_O <= rd_byte;
			DATA_OE_O <= ~p.oe_n & is_read(cmd_q);
			READY_BUSY_N_O <= ~(wr_start || (state_q == NVPP_BUSY
				&& busy_cnt_q != BUSY_N - CW'(1)));
			FUSE_STATE_O <= fuse_q;
			LOCK_STATE_O <= lock_q;
		end
	end

	// helper: length so far of the current busy-low stretch, cleared while ready is high
	logic [CW-1:0] low_len_q;
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I || READY_BUSY_N_O) begin
			low_len_q <= '0;
		end else begin
			low_len_q <= low_len_q + CW'(1);
		end
	end

	// checks
	a_cmd_frozen_busy: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		!idle |=> $stable(cmd_q) && $stable(addr_hi_q) && $stable(addr_lo_q))
		else $error("command or address changed while busy");
	a_busy_starts_low: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		wr_start |=> !READY_BUSY_N_O ##1 !READY_BUSY_N_O)
		else $error("write strobe did not drive busy low");
	a_busy_low_len: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		$rose(READY_BUSY_N_O) |-> $past(low_len_q) == BUSY_N - CW'(1))
		else $error("busy low for wrong number of cycles");
	a_ready_when_free: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		idle && !wr_start |=> READY_BUSY_N_O)
		else $error("busy shown without an operation");
	a_bus_drive_gate: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		DATA_OE_O |-> $past(!OUTPUT_ENABLE_N_I) && is_read($past(cmd_q)))
		else $error("data bus driven without read");
	a_cmd_load_xa: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		lsc_rise && idle && p.xa == `NVPP_XA_CMD |=> cmd_q == $past(DATA_I))
		else $error("command byte not loaded");
	a_lock_only_prog: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		state_q != NVPP_ERASE |=> (lock_q & ~$past(lock_q)) == 2'h0)
		else $error("lock bit raised outside erase");
	a_fuse_no_busy: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		idle && cmd_q == `NVPP_CMD_FUSE_WR |=> READY_BUSY_N_O [*2])
		else $error("fuse write showed busy");
	a_flash_hi_byte: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
		cmd_q == `NVPP_CMD_FLASH_RD && BYTE_SELECT_I |=> DATA_O == $past(f_rd[15:8]))
		else $error("flash high byte not selected");

	c_ee_write: cover property (@(posedge CLOCK_I) wr_start && cmd_q == `NVPP_CMD_EE_WR);
	c_chip_erase: cover property (@(posedge CLOCK_I) state_q == NVPP_ERASE && sweep_q == '1);
	c_fuse_write: cover property (@(posedge CLOCK_I)
		wr_rise && cmd_q == `NVPP_CMD_FUSE_WR && wr_cnt_q >= FUSE_N);
	c_sig_read: cover property (@(posedge CLOCK_I) DATA_OE_O && cmd_q == `NVPP_CMD_SIG_RD);
endmodule : nvpp_top

// ### tb/nvpp_prog_model.sv
// programmer model: drives the parallel programming pins and resolves the data bus
// assumes the device samples every pin on the rising clock edge
`timescale 1ns/1ps

module nvpp_prog_model (
	// clock
	input wire logic clk_i,
	// device side of the bus
	input wire logic [7:0] dev_data_i,
	input wire logic dev_oe_i,
	// programming pins
	output logic [1:0] xa_o,
	output logic bs_o,
	output logic lsc_o,
	output logic wr_n_o,
	output logic oe_n_o,
	output logic page_latch_strobe_o,
	output logic [7:0] bus_o
);
	logic [7:0] drv_q = 8'h00;
	logic [7:0] float_q = 8'h0f;

	// idle pin levels
	initial begin
		xa_o = 2'h3;
		bs_o = 1'b0;
		lsc_o = 1'b0;
		wr_n_o = 1'b1;
		oe_n_o = 1'b1;
		page_latch_strobe_o = 1'b0;
	end

	// an undriven bus shows a pattern that changes every cycle
	always_ff @(posedge clk_i) begin
		float_q <= ~float_q;
	end

	// the model releases the bus while output enable is low
	assign bus_o = dev_oe_i ? dev_data_i : (oe_n_o ? drv_q : float_q);

	// one load strobe pulse with action code, byte select and data held around it
	task automatic load(input logic [1:0] xa, input logic bs, input logic [7:0] d);
		@(posedge clk_i);
		xa_o <= xa;
		bs_o <= bs;
		drv_q <= d;
		@(posedge clk_i);
		lsc_o <= 1'b1;
		@(posedge clk_i);
		lsc_o <= 1'b0;
	endtask : load

	// page latch pulse for the selected byte
	task automatic latch(input logic bs);
		@(posedge clk_i);
		bs_o <= bs;
		@(posedge clk_i);
		page_latch_strobe_o <= 1'b1;
		@(posedge clk_i);
		page_latch_strobe_o <= 1'b0;
	endtask : latch

	// write strobe low for n cycles; fuse and erase pulses use long n
	task automatic write(input logic bs, input int n);
		@(posedge clk_i);
		bs_o <= bs;
		@(posedge clk_i);
		wr_n_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		wr_n_o <= 1'b1;
	endtask : write

	// output enable low, let the byte settle, take it from the bus
	task automatic read(input logic bs, output logic [7:0] d, output logic oe);
		@(posedge clk_i);
		bs_o <= bs;
		oe_n_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		d = bus_o;
		oe = dev_oe_i;
		@(posedge clk_i);
		oe_n_o <= 1'b1;
		@(posedge clk_i);
	endtask : read
endmodule : nvpp_prog_model

// ### tb/tb.sv
// self-checking bench of the parallel programming port
// assumes the programmer model drives every pin; short busy, fuse and erase counts
`timescale 1ns/1ps
`define CHK(g, e) check(8'(g), 8'(e))

module tb;
	localparam int BUSY = 20;
	localparam int FUSE = 30;
	localparam int ERASE = 40;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] xa;
	logic bs, lsc, wr_n, oe_n, page_latch_strobe, doe, rdy;
	logic [7:0] bus, dout, fuse;
	logic [1:0] lock;
	int mismatches = 0;
	int tests_run = 0;
	int busy_run = 0;
	int last_busy = 0;

	// clock
	initial begin
		forever #50 clk = ~clk;
	end

	// measure each busy period between clock edges
	always @(negedge clk) begin
		if (rdy === 1'b0) begin
			busy_run++;
		end else begin
			if (busy_run != 0) last_busy = busy_run;
			busy_run = 0;
		end
	end

	nvpp_prog_model nvpp_prog_model_i (.clk_i(clk), .dev_data_i(dout), .dev_oe_i(doe),
		.xa_o(xa), .bs_o(bs), .lsc_o(lsc), .wr_n_o(wr_n), .oe_n_o(oe_n), .page_latch_strobe_o(page_latch_strobe),
		.bus_o(bus));

	nvpp_top #(.FLASH_AW(9), .EE_AW(4), .BUSY_CYC(BUSY), .FUSE_MIN_CYC(FUSE),
		.ERASE_MIN_CYC(ERASE)) nvpp_top_i (.CLOCK_I(clk), .SYS_RST_I(rst),
		.XTAL_ACTION_HI_I(xa[1]), .XTAL_ACTION_LO_I(xa[0]), .BYTE_SELECT_I(bs),
		.LOAD_STROBE_CLOCK_I(lsc), .WRITE_STROBE_N_I(wr_n), .OUTPUT_ENABLE_N_I(oe_n),
		.PAGE_LATCH_STROBE_I(page_latch_strobe), .DATA_I(bus), .DATA_O(dout), .DATA_OE_O(doe),
		.READY_BUSY_N_O(rdy), .FUSE_STATE_O(fuse), .LOCK_STATE_O(lock));

	// verdict and end of run
	task automatic end_of_test();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// compare and count
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check

	// bounded wait for ready
	task automatic wait_ready();
		int i;
		// a strobe taken at this very edge shows busy only after it
		@(negedge clk);
		for (i = 0; i < 200 && rdy !== 1'b1; i++) @(negedge clk);
		repeat (2) @(negedge clk);
		if (rdy !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t: ready timeout", $time);
			end_of_test();
		end
	endtask : wait_ready

	// read one byte and compare, bus must be driven by the device
	task automatic rd_chk(input logic bs_v, input logic [7:0] e);
		logic [7:0] d;
		logic oe;
		nvpp_prog_model_i.read(bs_v, d, oe);
		`CHK(oe, 1'b1);
		`CHK(d, e);
	endtask : rd_chk

	// chip erase pulse and sweep
	task automatic t_erase();
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h80);
		nvpp_prog_model_i.write(1'b0, ERASE + 5);
		repeat (600) @(posedge clk);
		`CHK(lock, 2'h3);
	endtask : t_erase

	// eeprom writes, busy timing, frozen command and address
	task automatic t_eeprom();
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h11);
		nvpp_prog_model_i.load(2'h0, 1'b1, 8'h00);
		nvpp_prog_model_i.load(2'h0, 1'b0, 8'h05);
		nvpp_prog_model_i.load(2'h1, 1'b0, 8'h3c);
		nvpp_prog_model_i.write(1'b0, 1);
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h03);
		nvpp_prog_model_i.load(2'h0, 1'b0, 8'h09);
		wait_ready();
		`CHK(last_busy, BUSY);
		nvpp_prog_model_i.load(2'h1, 1'b0, 8'h4b);
		nvpp_prog_model_i.write(1'b0, 1);
		wait_ready();
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h03);
		rd_chk(1'b0, 8'h4b);
		nvpp_prog_model_i.load(2'h0, 1'b0, 8'h09);
		rd_chk(1'b0, 8'hff);
	endtask : t_eeprom

	// flash word write and byte-selected read
	task automatic t_flash();
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h10);
		nvpp_prog_model_i.load(2'h0, 1'b1, 8'h01);
		nvpp_prog_model_i.load(2'h0, 1'b0, 8'h02);
		nvpp_prog_model_i.load(2'h1, 1'b0, 8'h12);
		nvpp_prog_model_i.latch(1'b0);
		nvpp_prog_model_i.load(2'h1, 1'b1, 8'h34);
		nvpp_prog_model_i.latch(1'b1);
		nvpp_prog_model_i.write(1'b1, 1);
		repeat (3) @(negedge clk);
		`CHK(rdy, 1'b1);
		nvpp_prog_model_i.write(1'b0, 1);
		wait_ready();
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h02);
		rd_chk(1'b0, 8'h12);
		rd_chk(1'b1, 8'h34);
		nvpp_prog_model_i.load(2'h0, 1'b0, 8'h03);
		rd_chk(1'b0, 8'hff);
	endtask : t_flash

	// fuse write: short pulse ignored, long pulse takes, no busy
	task automatic t_fuse();
		last_busy = 0;
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h40);
		nvpp_prog_model_i.load(2'h1, 1'b0, 8'hf5);
		nvpp_prog_model_i.write(1'b0, 10);
		repeat (4) @(negedge clk);
		`CHK(fuse, 8'hff);
		nvpp_prog_model_i.write(1'b0, FUSE + 5);
		repeat (4) @(negedge clk);
		`CHK(fuse, 8'hf5);
		`CHK(last_busy, 0);
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h04);
		rd_chk(1'b0, 8'hf5);
	endtask : t_fuse

	// lock write, no way back except erase
	task automatic t_lock();
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h20);
		nvpp_prog_model_i.load(2'h1, 1'b0, 8'hfb);
		nvpp_prog_model_i.write(1'b0, 1);
		wait_ready();
		`CHK(lock, 2'h1);
		nvpp_prog_model_i.load(2'h1, 1'b0, 8'hff);
		nvpp_prog_model_i.write(1'b0, 1);
		wait_ready();
		`CHK(lock, 2'h1);
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h04);
		rd_chk(1'b1, 8'hfb);
		t_erase();
		// eeprom keep fuse was programmed by the fuse scenario: data survives
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h03);
		nvpp_prog_model_i.load(2'h0, 1'b0, 8'h05);
		rd_chk(1'b0, 8'h4b);
	endtask : t_lock

	// signature bytes and one address beyond them
	task automatic t_sig();
		logic [7:0] e [4] = '{8'h5a, 8'ha5, 8'h3c, 8'hff};
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h08);
		for (int i = 0; i < 4; i++) begin
			nvpp_prog_model_i.load(2'h0, 1'b0, 8'(i));
			rd_chk(1'b0, e[i]);
		end
	endtask : t_sig

	// bus stays released with a write command loaded
	task automatic t_hiz();
		logic [7:0] d;
		logic oe;
		nvpp_prog_model_i.load(2'h2, 1'b0, 8'h11);
		nvpp_prog_model_i.read(1'b0, d, oe);
		`CHK(oe, 1'b0);
	endtask : t_hiz

	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK(rdy, 1'b1);
		`CHK(fuse, 8'hff);
		`CHK(doe, 1'b0);
		t_erase();
		t_eeprom();
		t_flash();
		t_fuse();
		t_lock();
		t_sig();
		t_hiz();
		end_of_test();
	end
endmodule : tb
